// File: bwhbp_cfg.svh
// constants of the byte-wide host bus port: map, straps and timing
`ifndef BWHBP_CFG_SVH
`define BWHBP_CFG_SVH

// address window and its two regions, byte addresses
`define BWHBP_ADDR_W          17
`define BWHBP_BUF_BASE        17'h0_0000
`define BWHBP_BUF_BYTES       17'h1_4000
`define BWHBP_BUF_WORDS       40960
`define BWHBP_REG_BASE        17'h1_FFE0
`define BWHBP_REG_WORDS       16
`define BWHBP_REG_RESET       16'h0000
`define BWHBP_UNMAPPED_READ   16'h0000

// panel power enable: bit 0 of register word 1 (byte offset 1FFE2h)
`define BWHBP_PWR_REG_IDX     4'h1
`define BWHBP_PWR_BIT         0

// strap pattern that selects the generic 16-bit bus
`define BWHBP_GENERIC_SEL     4'hF

// released data bus level when nobody drives it
`define BWHBP_BUS_IDLE        8'hFF

// host timing at sys_clk
`define BWHBP_SYS_CLK_NS      50
`define BWHBP_RST_HOLD_NS     400
`define BWHBP_RST_HOLD_CYC    ((`BWHBP_RST_HOLD_NS + `BWHBP_SYS_CLK_NS - 1) / `BWHBP_SYS_CLK_NS)
`define BWHBP_SETTLE_CYC      6
`define BWHBP_GAP_CYC         4

`endif

// File: bwhbp_chk.sv
// concurrent checks on the board link between host glue and device port
module bwhbp_chk (
    input wire logic        hostBusClock,
    input wire logic        deviceResetN,
    input wire logic [16:0] cpuAddr,
    input wire logic        chipSelectN,
    input wire logic        readStrobeN,
    input wire logic        writeStrobeN,
    input wire logic        highByteEnableN,
    input wire logic        waitN,
    input wire logic [1:0]  devDataOe,
    input wire logic        busStatusStrap,
    input wire logic        readWriteDirStrap,
    input wire logic [2:0]  busSelectStrap
);
    default clocking cb @(posedge hostBusClock);
    endclocking
    default disable iff (!deviceResetN);

    // a fresh cycle: exactly one strobe newly low under chip select
    sequence sTake;
        !chipSelectN && (readStrobeN ^ writeStrobeN) && $past(readStrobeN && writeStrobeN);
    endsequence

    // bound covers the longest refresh hold the bench applies
    sequence sHoldOff;
        !waitN ##[1:80] waitN;
    endsequence

    a_wait_on_take: assert property (sTake |=> sHoldOff)
        else $error("wait did not pulse after a strobe");
    a_wait_idle: assert property (readStrobeN && writeStrobeN && $past(readStrobeN && writeStrobeN) |-> waitN)
        else $error("wait low with no cycle open");
    a_data_with_wait: assert property ($rose(waitN) && !readStrobeN |-> devDataOe == {cpuAddr[0], !cpuAddr[0]})
        else $error("read lane not driven as wait released");
    a_release_quiet: assert property (readStrobeN && $past(readStrobeN) |-> devDataOe == 2'h0)
        else $error("device drives data outside a read");
    a_no_drive_write: assert property (!writeStrobeN |-> devDataOe == 2'h0)
        else $error("device drives data during a write");
    a_lane_by_bhe: assert property (devDataOe != 2'h0 && !readStrobeN |-> devDataOe == {!highByteEnableN, highByteEnableN})
        else $error("driven lane disagrees with high byte enable");
    a_bhe_from_a0: assert property (!chipSelectN |-> highByteEnableN == !cpuAddr[0])
        else $error("high byte enable not inverted address bit 0");
    a_straps_tied: assert property (busStatusStrap && readWriteDirStrap && busSelectStrap == 3'h7)
        else $error("bus straps not tied for generic mode");
    a_hold_in_wait: assert property (!chipSelectN && !waitN |=> !chipSelectN && $stable(cpuAddr) && $stable({readStrobeN, writeStrobeN}))
        else $error("host moved the cycle while held off");
endmodule : bwhbp_chk

// File: bwhbp_device.sv
// device end: 16-bit generic host port with display buffer and registers
// What this block does
// - host drives write strobe low to write
// - host drives read strobe low to read
// - wait output marks read valid, write accepted
// - wait held until refresh arbitration finishes
// - wait is active low; glue may invert
// - bus status, direction ignored during cycles
// - board ties bus status strap high
// - board ties direction input high
// - high byte enable is inverted address bit0
// - 8-bit data feeds both byte lanes
// - straps sampled at first bus clock edge after reset release
// - byte order strap: low little, high big
// - polarity strap sets panel power active level
// - all four bus straps high: generic mode
// - 128K window holds buffer and registers
// - display buffer starts at offset zero
// - 32 register bytes from offset 1FFE0h
// - external decode selects on every window access
// - transfers timed by separate host bus clock
// - high byte enable qualifies reads and writes
`include "bwhbp_cfg.svh"

module bwhbp_device (
    bwhbp_link.dev             link,
    input  wire logic          refreshReq,
    input  wire logic [15:0]   refreshAddr,
    output logic               refreshGrant,
    output logic [15:0]        refreshData,
    output logic               panelPowerOut,
    output logic               genericMode,
    output logic               bigEndian
);

    bwhbp_pkg::bwhbp_dev_s     q;
    bwhbp_pkg::bwhbp_dev_s     d;
    logic [15:0]               bufMem [`BWHBP_BUF_WORDS];

    logic                      hostRd;
    logic                      hostWr;
    logic                      loEn;
    logic                      hiEn;
    bwhbp_pkg::bwhbp_region_e  region;
    logic [1:0]                byteMask;
    logic [15:0]               laneWord;
    logic [15:0]               oldWord;
    logic [15:0]               mergedWord;
    logic [15:0]               refreshWord;
    logic [15:0]               memIdx;
    logic                      memWe;
    logic                      pwrOn;

    // window split into buffer, hole and register block
    function automatic bwhbp_pkg::bwhbp_region_e regionOf(input logic [16:0] addr);
        bwhbp_pkg::bwhbp_region_e rgn;
        rgn = bwhbp_pkg::RGN_NONE;
        if (addr >= `BWHBP_REG_BASE)
        begin
            rgn = bwhbp_pkg::RGN_REGS;
        end
        else if (addr >= `BWHBP_BUF_BASE && addr < `BWHBP_BUF_BYTES)
        begin
            rgn = bwhbp_pkg::RGN_BUF;
        end
        return rgn;
    endfunction : regionOf

    function automatic logic [15:0] swapBytes(input logic [15:0] w);
        return {w[7:0], w[15:8]};
    endfunction : swapBytes

    always_comb
    begin
        d           = q;
        memWe       = 1'b0;
        memIdx      = link.cpuAddr[16:1];
        // only chip select and the two strobes qualify a cycle
        hostRd      = !link.chipSelectN && !link.readStrobeN && link.writeStrobeN;
        hostWr      = !link.chipSelectN && !link.writeStrobeN && link.readStrobeN;
        region      = regionOf(link.cpuAddr);
        // upper lane gated on reads and writes alike
        loEn        = !link.cpuAddr[0];
        hiEn        = !link.highByteEnableN;
        // big-endian stores the even byte in the upper half
        byteMask    = q.bigEndian ? {loEn, hiEn} : {hiEn, loEn};
        laneWord    = q.bigEndian ? swapBytes(link.deviceDataLanes) : link.deviceDataLanes;
        oldWord     = `BWHBP_UNMAPPED_READ;
        unique case (region)
            bwhbp_pkg::RGN_BUF:  oldWord = bufMem[memIdx];
            bwhbp_pkg::RGN_REGS: oldWord = q.regs[link.cpuAddr[4:1]];
            bwhbp_pkg::RGN_NONE: oldWord = `BWHBP_UNMAPPED_READ;
        endcase
        mergedWord  = {byteMask[1] ? laneWord[15:8] : oldWord[15:8],
                       byteMask[0] ? laneWord[7:0]  : oldWord[7:0]};
        // address is only trusted while the display holds its request
        refreshWord = (refreshAddr < `BWHBP_BUF_WORDS) ? bufMem[refreshAddr] : 16'h0000;

        d.reqSync1  = refreshReq;
        d.reqSync2  = q.reqSync1;

        // first link edge after reset release catches every strap except the direction strap
        if (!q.strapsTaken)
        begin
            d.strapsTaken   = 1'b1;
            // generic bus only on the all-ones pattern
            d.genericMode   = ({link.busSelectStrap, link.busStatusStrap} == `BWHBP_GENERIC_SEL);
            d.bigEndian     = link.byteOrderStrap;
            d.powerPolarity = link.panelPowerPolarityStrap;
        end

        // panel power level follows the polarity strap
        pwrOn        = q.regs[`BWHBP_PWR_REG_IDX][`BWHBP_PWR_BIT];
        d.panelPower = q.strapsTaken && (q.powerPolarity ? pwrOn : !pwrOn);

        unique case (q.state)
            bwhbp_pkg::DEV_IDLE:
            begin
                if (q.genericMode && (hostRd || hostWr))
                begin
                    // wait drops as soon as a cycle is seen
                    d.waitN = 1'b0;
                    d.grant = q.grant && q.reqSync2;
                    d.state = bwhbp_pkg::DEV_ARB;
                end
                else
                begin
                    d.grant = q.reqSync2;
                end
                if (d.grant)
                begin
                    d.refreshData = refreshWord;
                end
            end
            bwhbp_pkg::DEV_ARB:
            begin
                if (!(hostRd || hostWr))
                begin
                    // strobe withdrawn early: abandon without side effects
                    d.waitN = 1'b1;
                    d.state = bwhbp_pkg::DEV_IDLE;
                end
                // refresh owns the buffer: keep the host waiting
                else if (q.grant && q.reqSync2)
                begin
                    d.refreshData = refreshWord;
                end
                else
                begin
                    d.grant = 1'b0;
                    if (hostWr && region == bwhbp_pkg::RGN_BUF)
                    begin
                        memWe = 1'b1;
                    end
                    if (hostWr && region == bwhbp_pkg::RGN_REGS)
                    begin
                        d.regs[link.cpuAddr[4:1]] = mergedWord;
                    end
                    if (hostRd)
                    begin
                        d.rdData = q.bigEndian ? swapBytes(oldWord) : oldWord;
                        d.dataOe = {hiEn, loEn};
                    end
                    // release marks data valid or accepted
                    d.waitN = 1'b1;
                    d.state = bwhbp_pkg::DEV_DONE;
                end
            end
            bwhbp_pkg::DEV_DONE:
            begin
                // data stays driven until the strobe goes away
                if (!(hostRd || hostWr))
                begin
                    d.dataOe = 2'b00;
                    d.state  = bwhbp_pkg::DEV_IDLE;
                end
            end
            default:
            begin
                d.waitN  = 1'b1;
                d.dataOe = 2'b00;
                d.grant  = 1'b0;
                d.state  = bwhbp_pkg::DEV_IDLE;
            end
        endcase
    end

    // every device flop runs on the host bus clock
    always_ff @(posedge link.hostBusClock or negedge link.deviceResetN)
    begin
        if (!link.deviceResetN)
        begin
            q       <= '0;
            q.waitN <= 1'b1;
            q.regs  <= {`BWHBP_REG_WORDS{`BWHBP_REG_RESET}};
        end
        else
        begin
            q <= d;
        end
    end

    // buffer has no reset; contents are undefined until written
    always_ff @(posedge link.hostBusClock)
    begin
        if (memWe)
        begin
            bufMem[memIdx] <= mergedWord;
        end
    end

    assign link.waitN      = q.waitN;
    assign link.devDataOut = q.rdData;
    assign link.devDataOe  = q.dataOe;
    assign refreshGrant    = q.grant;
    assign refreshData     = q.refreshData;
    assign panelPowerOut   = q.panelPower;
    assign genericMode     = q.genericMode;
    assign bigEndian       = q.bigEndian;

endmodule : bwhbp_device

// File: bwhbp_host.sv
// host end: 8-bit processor glue driving the device port
`include "bwhbp_cfg.svh"

module bwhbp_host (
    bwhbp_link.host            link,
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          cmdValid,
    input  wire logic          cmdWrite,
    input  wire logic [16:0]   cmdAddr,
    input  wire logic [7:0]    cmdWdata,
    input  wire logic          bigEndianSel,
    input  wire logic          panelPowerActiveHigh,
    output logic               cmdReady,
    output logic               rspValid,
    output logic [7:0]         rspData
);

    localparam logic [3:0] RST_LAST    = 4'(`BWHBP_RST_HOLD_CYC - 1);
    localparam logic [3:0] SETTLE_LAST = 4'(`BWHBP_SETTLE_CYC - 1);
    localparam logic [3:0] GAP_LAST    = 4'(`BWHBP_GAP_CYC - 1);

    bwhbp_pkg::bwhbp_host_s    q;
    bwhbp_pkg::bwhbp_host_s    d;
    logic                      fallEdge;

    always_comb
    begin
        d           = q;
        d.rspValid  = 1'b0;
        // bus clock is sys_clk / 2; bus pins move only as it falls
        d.clkDiv    = !q.clkDiv;
        fallEdge    = q.clkDiv;
        d.waitSync1 = link.waitN;
        d.waitSync2 = q.waitSync1;
        d.dataSync1 = link.cpuData;
        d.dataSync2 = q.dataSync1;

        unique case (q.state)
            bwhbp_pkg::HST_RESET:
            begin
                // straps settle while the device sits in reset
                d.byteOrder   = bigEndianSel;
                d.pwrPolarity = panelPowerActiveHigh;
                if (q.cnt >= RST_LAST && fallEdge)
                begin
                    d.devResetN = 1'b1;
                    d.cmdReady  = 1'b1;
                    d.state     = bwhbp_pkg::HST_IDLE;
                end
                else if (q.cnt < RST_LAST)
                begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            bwhbp_pkg::HST_IDLE:
            begin
                if (cmdValid && q.cmdReady && fallEdge)
                begin
                    d.cmdReady = 1'b0;
                    d.addr     = cmdAddr;
                    d.wdata    = cmdWdata;
                    d.isWrite  = cmdWrite;
                    // every command lies inside the device window
                    d.csN      = 1'b0;
                    d.wrN      = !cmdWrite;
                    d.rdN      = cmdWrite;
                    // odd bytes ride the upper lane
                    d.bheN     = !cmdAddr[0];
                    d.dataOe   = cmdWrite;
                    d.cnt      = 4'h0;
                    d.state    = bwhbp_pkg::HST_SETTLE;
                end
            end
            bwhbp_pkg::HST_SETTLE:
            begin
                // lets the device's wait assertion pass the synchroniser
                if (q.cnt == SETTLE_LAST)
                begin
                    d.state = bwhbp_pkg::HST_WAIT;
                end
                else
                begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            bwhbp_pkg::HST_WAIT:
            begin
                // active-low wait; strobes held until released
                if (q.waitSync2 && fallEdge)
                begin
                    d.rspData  = q.isWrite ? q.wdata : q.dataSync2;
                    d.rspValid = 1'b1;
                    d.csN      = 1'b1;
                    d.rdN      = 1'b1;
                    d.wrN      = 1'b1;
                    d.dataOe   = 1'b0;
                    d.cnt      = 4'h0;
                    d.state    = bwhbp_pkg::HST_GAP;
                end
            end
            bwhbp_pkg::HST_GAP:
            begin
                if (q.cnt == GAP_LAST)
                begin
                    d.cmdReady = 1'b1;
                    d.state    = bwhbp_pkg::HST_IDLE;
                end
                else
                begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            default:
            begin
                d.state = bwhbp_pkg::HST_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            q       <= '0;
            q.csN   <= 1'b1;
            q.rdN   <= 1'b1;
            q.wrN   <= 1'b1;
            q.bheN  <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.hostBusClock            = q.clkDiv;
    assign link.deviceResetN            = q.devResetN;
    assign link.cpuAddr                 = q.addr;
    assign link.chipSelectN             = q.csN;
    assign link.readStrobeN             = q.rdN;
    assign link.writeStrobeN            = q.wrN;
    assign link.highByteEnableN         = q.bheN;
    assign link.hostDataOut             = q.wdata;
    assign link.hostDataOe              = q.dataOe;
    assign link.busStatusStrap          = 1'b1;
    assign link.readWriteDirStrap       = 1'b1;
    assign link.busSelectStrap          = 3'h7;
    assign link.byteOrderStrap          = q.byteOrder;
    assign link.panelPowerPolarityStrap = q.pwrPolarity;
    assign cmdReady                     = q.cmdReady;
    assign rspValid                     = q.rspValid;
    assign rspData                      = q.rspData;

endmodule : bwhbp_host

// File: bwhbp_link.sv
// board wiring between the 8-bit host glue and the 16-bit device port
`include "bwhbp_cfg.svh"

interface bwhbp_link;
    logic        hostBusClock;
    logic        deviceResetN;
    logic [16:0] cpuAddr;
    logic        chipSelectN;
    logic        readStrobeN;
    logic        writeStrobeN;
    logic        highByteEnableN;
    logic        waitN;
    logic [7:0]  hostDataOut;
    logic        hostDataOe;
    logic [15:0] devDataOut;
    logic [1:0]  devDataOe;
    logic [7:0]  cpuData;
    logic [15:0] deviceDataLanes;
    logic        busStatusStrap;
    logic        readWriteDirStrap;
    logic [2:0]  busSelectStrap;
    logic        byteOrderStrap;
    logic        panelPowerPolarityStrap;

    // the 8-bit host bus is tied to both device lanes
    assign cpuData = devDataOe[0] ? devDataOut[7:0] :
                     devDataOe[1] ? devDataOut[15:8] :
                     hostDataOe   ? hostDataOut : `BWHBP_BUS_IDLE;
    assign deviceDataLanes = {cpuData, cpuData};

    modport dev (
        input  hostBusClock, deviceResetN, cpuAddr, chipSelectN, readStrobeN,
        input  writeStrobeN, highByteEnableN, deviceDataLanes, busStatusStrap,
        input  readWriteDirStrap, busSelectStrap, byteOrderStrap, panelPowerPolarityStrap,
        output waitN, devDataOut, devDataOe
    );

    modport host (
        output hostBusClock, deviceResetN, cpuAddr, chipSelectN, readStrobeN,
        output writeStrobeN, highByteEnableN, hostDataOut, hostDataOe, busStatusStrap,
        output readWriteDirStrap, busSelectStrap, byteOrderStrap, panelPowerPolarityStrap,
        input  waitN, cpuData
    );
endinterface : bwhbp_link

// File: bwhbp_pkg.sv
// types of the byte-wide host bus port
package bwhbp_pkg;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_ARB  = 2'b01,
        DEV_DONE = 2'b10
    } bwhbp_dev_state_e;

    typedef enum logic [1:0] {
        RGN_NONE = 2'b00,
        RGN_BUF  = 2'b01,
        RGN_REGS = 2'b10
    } bwhbp_region_e;

    typedef enum logic [2:0] {
        HST_RESET  = 3'b000,
        HST_IDLE   = 3'b001,
        HST_SETTLE = 3'b010,
        HST_WAIT   = 3'b011,
        HST_GAP    = 3'b100
    } bwhbp_host_state_e;

    typedef struct packed {
        bwhbp_dev_state_e  state;
        logic              strapsTaken;
        logic              genericMode;
        logic              bigEndian;
        logic              powerPolarity;
        logic              reqSync1;
        logic              reqSync2;
        logic              grant;
        logic              waitN;
        logic [15:0]       rdData;
        logic [1:0]        dataOe;
        logic [15:0]       refreshData;
        logic              panelPower;
        logic [15:0][15:0] regs;
    } bwhbp_dev_s;

    typedef struct packed {
        bwhbp_host_state_e state;
        logic              clkDiv;
        logic              devResetN;
        logic [3:0]        cnt;
        logic [16:0]       addr;
        logic [7:0]        wdata;
        logic              isWrite;
        logic              csN;
        logic              rdN;
        logic              wrN;
        logic              bheN;
        logic              dataOe;
        logic              byteOrder;
        logic              pwrPolarity;
        logic              waitSync1;
        logic              waitSync2;
        logic [7:0]        dataSync1;
        logic [7:0]        dataSync2;
        logic              cmdReady;
        logic              rspValid;
        logic [7:0]        rspData;
    } bwhbp_host_s;

endpackage : bwhbp_pkg

// File: bwhbp_tb.sv
// self-checking bench: host glue and device port joined over the board link
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk;
    logic        arst_n;
    logic        cmdValid;
    logic        cmdWrite;
    logic [16:0] cmdAddr;
    logic [7:0]  cmdWdata;
    logic        bigEndianSel;
    logic        panelPowerActiveHigh;
    logic        cmdReady;
    logic        rspValid;
    logic [7:0]  rspData;
    logic        refreshReq;
    logic [15:0] refreshAddr;
    logic        refreshGrant;
    logic [15:0] refreshData;
    logic        panelPowerOut;
    logic        genericMode;
    logic        bigEndian;
    logic        genericMode2;
    logic        linkClk2;
    logic [7:0]  q;
    int          miscompares;
    int          checks;
    int          wn;
    int          bad;
    time         t0;

    bwhbp_link link();
    bwhbp_link link2();

    bwhbp_host bwhbp_host_i (.link(link), .sys_clk(sys_clk), .arst_n(arst_n),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
        .bigEndianSel(bigEndianSel), .panelPowerActiveHigh(panelPowerActiveHigh),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData));
    bwhbp_device bwhbp_device_i (.link(link), .refreshReq(refreshReq),
        .refreshAddr(refreshAddr), .refreshGrant(refreshGrant), .refreshData(refreshData),
        .panelPowerOut(panelPowerOut), .genericMode(genericMode), .bigEndian(bigEndian));
    // second device on a bench-driven link, strapped for a foreign bus
    bwhbp_device bwhbp_device_i2 (.link(link2), .refreshReq(1'h0), .refreshAddr(16'h0000),
        .refreshGrant(), .refreshData(), .panelPowerOut(), .genericMode(genericMode2),
        .bigEndian());
    bwhbp_chk bwhbp_chk_i (.hostBusClock(link.hostBusClock), .deviceResetN(link.deviceResetN),
        .cpuAddr(link.cpuAddr), .chipSelectN(link.chipSelectN),
        .readStrobeN(link.readStrobeN), .writeStrobeN(link.writeStrobeN),
        .highByteEnableN(link.highByteEnableN), .waitN(link.waitN),
        .devDataOe(link.devDataOe), .busStatusStrap(link.busStatusStrap),
        .readWriteDirStrap(link.readWriteDirStrap), .busSelectStrap(link.busSelectStrap));

    assign link2.hostBusClock = linkClk2;

    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        linkClk2 = 1'h0;
        #7;
        forever #24 linkClk2 = ~linkClk2;
    end

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // every open-ended wait loop funnels through here so a hang ends the run
    task automatic tick(inout int n);
        @(negedge sys_clk);
        n++;
        if (n > 3000)
        begin
            miscompares++;
            $display("MISMATCH %0t wait ran out", $time);
            close_out();
        end
    endtask : tick

    task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d,
                        output logic [7:0] r);
        int n;
        n = 0;
        while (cmdReady !== 1'h1)
            tick(n);
        @(posedge sys_clk);
        cmdValid <= 1'h1;
        cmdWrite <= wr;
        cmdAddr  <= a;
        cmdWdata <= d;
        while (cmdReady !== 1'h0)
            tick(n);
        @(posedge sys_clk);
        cmdValid <= 1'h0;
        while (rspValid !== 1'h1)
            tick(n);
        r = rspData;
    endtask : xfer

    task automatic wr_rd(input logic [16:0] a, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        xfer(1'h1, a, d, r);
        check({8'h00, r}, {8'h00, d});
        xfer(1'h0, a, 8'h00, r);
        check({8'h00, r}, {8'h00, exp});
    endtask : wr_rd

    initial
    begin
        arst_n = 1'h0;
        cmdValid = 1'h0;
        cmdWrite = 1'h0;
        cmdAddr = 17'h0_0000;
        cmdWdata = 8'h00;
        bigEndianSel = 1'h0;
        panelPowerActiveHigh = 1'h0;
        refreshReq = 1'h0;
        refreshAddr = 16'h0000;
        link2.deviceResetN = 1'h0;
        link2.cpuAddr = 17'h0_0000;
        {link2.chipSelectN, link2.readStrobeN, link2.writeStrobeN} = 3'h7;
        link2.highByteEnableN = 1'h1;
        link2.hostDataOut = 8'h00;
        link2.hostDataOe = 1'h0;
        {link2.busStatusStrap, link2.readWriteDirStrap} = 2'h3;
        link2.busSelectStrap = 3'h6;
        {link2.byteOrderStrap, link2.panelPowerPolarityStrap} = 2'h0;
        for (int p = 0; p < 2; p++)
        begin
            @(posedge sys_clk);
            arst_n <= 1'h0;
            bigEndianSel <= p[0];
            panelPowerActiveHigh <= p[0];
            repeat (3) @(posedge sys_clk);
            arst_n <= 1'h1;
            xfer(1'h0, 17'h1_FFE6, 8'h00, q);
            check({8'h00, q}, 16'h0000);
            wr_rd(17'h0_0000, 8'h11, 8'h11);
            wr_rd(17'h0_0001, 8'h22, 8'h22);
            wr_rd(17'h1_3FFF, 8'hA7, 8'hA7);
            wr_rd(17'h1_FFE0, 8'h3C, 8'h3C);
            wr_rd(17'h1_FFFF, 8'hC3, 8'hC3);
            wr_rd(17'h1_4000, 8'h99, 8'h00);
            wr_rd(17'h1_FFDF, 8'h66, 8'h00);
            check({15'h0000, genericMode}, 16'h0001);
            check({15'h0000, bigEndian}, {15'h0000, p[0]});
            // power enable is bit 0 of word 1: the odd byte when big-endian
            wr_rd({16'hFFF1, p[0]}, 8'h01, 8'h01);
            check({15'h0000, panelPowerOut}, {15'h0000, p[0]});
            wr_rd({16'hFFF1, p[0]}, 8'h00, 8'h00);
            check({15'h0000, panelPowerOut}, {15'h0000, !p[0]});
            @(posedge sys_clk);
            refreshReq <= 1'h1;
            wn = 0;
            while (refreshGrant !== 1'h1)
                tick(wn);
            repeat (4) @(negedge sys_clk);
            check(refreshData, p[0] ? 16'h1122 : 16'h2211);
            t0 = $time;
            fork
                begin
                    repeat (60) @(posedge sys_clk);
                    refreshReq <= 1'h0;
                end
                xfer(1'h0, 17'h0_0000, 8'h00, q);
            join
            check({8'h00, q}, 16'h0011);
            check({15'h0000, $time - t0 > 60 * 50}, 16'h0001);
            check({15'h0000, refreshGrant}, 16'h0000);
        end
        // foreign strap pattern: the cycle must be ignored entirely
        @(posedge linkClk2);
        link2.deviceResetN <= 1'h1;
        repeat (3) @(posedge linkClk2);
        link2.chipSelectN <= 1'h0;
        link2.readStrobeN <= 1'h0;
        bad = 0;
        repeat (10)
        begin
            @(negedge linkClk2);
            if (link2.waitN !== 1'h1 || link2.devDataOe !== 2'h0)
                bad++;
        end
        check(bad[15:0], 16'h0000);
        check({15'h0000, genericMode2}, 16'h0000);
        close_out();
    end
endmodule : tb
